/* shared/csl_consts.svh */
// Constants of the clock status latch and interrupt block: addresses, bit positions, resets.
// Assumes it is included by bare name from the package and the design file.
// Notes on behaviour
// - VCXO lock latch reads 0 after any loss of lock since last clear, else 1.
// - Writing 1 to VCXO lock latch restores it and withdraws its interrupt.
// - Each of four inputs has its own sticky loss-of-signal latch, 0 after an event.
// - Writing 1 to one input latch clears only that latch and its interrupt.
// - Two-bit read-only selection status shows the input in use, coded 0 to 3.
// - Momentary synth and VCXO lock bits read 0 on loss of lock, feed latches.
// - Each input has a momentary activity bit: 0 on loss of signal, 1 active.
// - Reference latch reads 0 if reference lost since last clear, else 1.
// - Writing 1 to reference latch clears it and its pending interrupt.
// - Holdover latch reads 0 if holdover was entered since last clear, else 1.
// - Writing 1 to holdover latch clears it and withdraws its interrupt.
// - Momentary calibration bit reads 1 while calibration runs, 0 when done.
// - Reference presence bit reads 1 when present, 0 when absent; feeds its latch.
// - Momentary holdover bit reads 0 in holdover, 1 while locked or locking.
// - Lock, input and holdover latches each have an enable, reset 0, gating the interrupt.
// - With enable set, a fall of the reference latch to 0 asserts the interrupt.
// - Synth lock latch reads 0 after loss of lock; write 1 clears it and interrupt.
`ifndef CSL_CONSTS_SVH
`define CSL_CONSTS_SVH

`define CSL_ADDR_IE_A        8'h68
`define CSL_ADDR_IE_B        8'h69
`define CSL_ADDR_LATCH_A     8'h6c
`define CSL_ADDR_NOW_A       8'h6d
`define CSL_ADDR_LATCH_B     8'h6e
`define CSL_ADDR_NOW_B       8'h6f

// Bit positions in the A group registers
`define CSL_BIT_SYNTH        5
`define CSL_BIT_VCXO         4
`define CSL_BIT_INPUT_LO     0
`define CSL_BIT_SEL_LO       6
// Bit positions in the B group registers
`define CSL_BIT_REF          1
`define CSL_BIT_HOLD         0
`define CSL_BIT_CAL          2

`define CSL_RST_IE           8'h00
`define CSL_RST_LATCH        1'b1
`define CSL_RST_IRQ_LOW      1'b1
`define CSL_RST_RDATA        8'h00
`define CSL_SYNC_STAGES      3

`endif

/* shared/csl_pkg.sv */
// Types shared by the clock status latch and interrupt block.
// Assumes the constants header sits on the include path.
`include "csl_consts.svh"

package csl_pkg;
    typedef logic [7:0] csl_byte_type;
    typedef logic [1:0] csl_sel_type;
    // Order of the synchronised detector vector
    typedef struct packed {
        logic       synth_lock;
        logic       vcxo_lock;
        logic [3:0] input_active;
        logic       reference_present;
        logic       holdover;
        logic       cal_active;
    } csl_det_type;
endpackage

/* verilog/csl_top.sv */
// Status latches, interrupt enables and active-low interrupt of the clock synthesizer.
// Assumes a serial port decoder on mclk that gives one-cycle write strobes and a
// held read address; detector inputs come from other clocks and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "csl_consts.svh"

module csl_top #(
    parameter int N_INPUTS = 4
) (
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic [7:0]           reg_addr,
    input  wire logic                 reg_wr,
    input  wire logic [7:0]           reg_wdata,
    output var  logic [7:0]           reg_rdata,
    input  wire logic                 synth_lock_raw,
    input  wire logic                 vcxo_lock_raw,
    input  wire logic [N_INPUTS-1:0]  input_active_raw,
    input  wire logic                 reference_present_raw,
    input  wire logic                 holdover_raw,
    input  wire logic                 synth_cal_raw,
    input  wire logic [1:0]           selected_input_status,
    output var  logic                 irq_out_low
);

    // Register layout and enable packing are fixed at four inputs, so refuse others
    if (N_INPUTS != 4) begin : g_bad_inputs
        $error("csl_top serves exactly four reference inputs");
    end

    // Register map of this block, one byte each:
    //   enable A   : synth lock, vcxo lock and four input enables, reset 0
    //   enable B   : reference and holdover enables, reset 0
    //   latch A    : synth, vcxo and four input latches, 0 means an event, write 1 clears
    //   momentary A: selection status on top, then synth, vcxo and input activity
    //   latch B    : reference and holdover latches, 0 means an event, write 1 clears
    //   momentary B: calibration, reference presence and holdover
    // Unmapped addresses read zero and ignore writes.

    localparam int DW = $bits(csl_pkg::csl_det_type);

    // Detector synchroniser: three stages, value moves only when the last two agree
    logic [DW-1:0]        sync1_r;
    logic [DW-1:0]        sync2_r;
    logic [DW-1:0]        sync3_r;
    csl_pkg::csl_det_type det_r;
    logic [DW-1:0]        sync1_nxt;
    csl_pkg::csl_det_type det_nxt;

    always_comb begin
        sync1_nxt = {synth_lock_raw, vcxo_lock_raw, input_active_raw,
                     reference_present_raw, holdover_raw, synth_cal_raw};
        det_nxt   = det_r;
        for (int i = 0; i < DW; i++) begin
            if (sync2_r[i] == sync3_r[i]) begin
                det_nxt[i] = sync3_r[i];
            end
        end
    end

    // Reset values assume a healthy, calibrating state so no false event is latched.
    // A reset to zero would show every detector but calibration as faulty for the first few edges
    // after release, and the latches would then hold events that never happened.
    // The price: a detector that is really faulty at release is seen a few edges late.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync1_r <= '1;
            sync2_r <= '1;
            sync3_r <= '1;
            det_r   <= '1;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            det_r   <= det_nxt;
        end
    end

    // Enables, latches and the reference-change pending flag
    logic                 synth_lock_irq_enable_r;
    logic                 vcxo_lock_irq_enable_r;
    logic [3:0]           input_los_irq_enable_r;
    logic                 reference_irq_enable_r;
    logic                 holdover_irq_enable_r;
    logic                 synth_lock_loss_latch_r;
    logic                 vcxo_lock_loss_latch_r;
    logic [3:0]           input_los_latch_r;
    logic                 reference_valid_latch_r;
    logic                 holdover_latch_r;
    logic                 ref_pend_r;
    logic                 synth_lock_irq_enable_nxt;
    logic                 vcxo_lock_irq_enable_nxt;
    logic [3:0]           input_los_irq_enable_nxt;
    logic                 reference_irq_enable_nxt;
    logic                 holdover_irq_enable_nxt;
    logic                 synth_lock_loss_latch_nxt;
    logic                 vcxo_lock_loss_latch_nxt;
    logic [3:0]           input_los_latch_nxt;
    logic                 reference_valid_latch_nxt;
    logic                 holdover_latch_nxt;
    logic                 ref_pend_nxt;
    logic                 wr_a;
    logic                 wr_b;
    logic                 clr_a;
    logic                 clr_b;

    // Clear first, capture after, so a fault present at the clear is kept
    function automatic logic sticky(input logic cur, input logic clr, input logic ok);
        logic v;
        v = clr ? `CSL_RST_LATCH : cur;
        if (!ok) begin
            v = 1'b0;
        end
        return v;
    endfunction

    // The A group layout is shared by the enable, latch and momentary registers
    function automatic csl_pkg::csl_byte_type pack_a(input logic       synth,
                                                     input logic       vcxo,
                                                     input logic [3:0] inputs);
        csl_pkg::csl_byte_type b;
        b                         = 8'h00;
        b[`CSL_BIT_SYNTH]         = synth;
        b[`CSL_BIT_VCXO]          = vcxo;
        b[`CSL_BIT_INPUT_LO +: 4] = inputs;
        return b;
    endfunction

    // The B group layout is shared by the enable and latch registers
    function automatic csl_pkg::csl_byte_type pack_b(input logic ref_bit,
                                                     input logic hold_bit);
        csl_pkg::csl_byte_type b;
        b                 = 8'h00;
        b[`CSL_BIT_REF]   = ref_bit;
        b[`CSL_BIT_HOLD]  = hold_bit;
        return b;
    endfunction

    always_comb begin
        wr_a  = reg_wr && (reg_addr == `CSL_ADDR_IE_A);
        wr_b  = reg_wr && (reg_addr == `CSL_ADDR_IE_B);
        clr_a = reg_wr && (reg_addr == `CSL_ADDR_LATCH_A);
        clr_b = reg_wr && (reg_addr == `CSL_ADDR_LATCH_B);
        synth_lock_irq_enable_nxt = synth_lock_irq_enable_r;
        vcxo_lock_irq_enable_nxt  = vcxo_lock_irq_enable_r;
        input_los_irq_enable_nxt  = input_los_irq_enable_r;
        reference_irq_enable_nxt  = reference_irq_enable_r;
        holdover_irq_enable_nxt   = holdover_irq_enable_r;
        if (wr_a) begin
            synth_lock_irq_enable_nxt = reg_wdata[`CSL_BIT_SYNTH];
            vcxo_lock_irq_enable_nxt  = reg_wdata[`CSL_BIT_VCXO];
            input_los_irq_enable_nxt  = reg_wdata[`CSL_BIT_INPUT_LO +: 4];
        end
        if (wr_b) begin
            reference_irq_enable_nxt = reg_wdata[`CSL_BIT_REF];
            holdover_irq_enable_nxt  = reg_wdata[`CSL_BIT_HOLD];
        end
        synth_lock_loss_latch_nxt = sticky(synth_lock_loss_latch_r,
                                           clr_a && reg_wdata[`CSL_BIT_SYNTH],
                                           det_r.synth_lock);
        vcxo_lock_loss_latch_nxt  = sticky(vcxo_lock_loss_latch_r,
                                           clr_a && reg_wdata[`CSL_BIT_VCXO],
                                           det_r.vcxo_lock);
        for (int i = 0; i < 4; i++) begin
            input_los_latch_nxt[i] = sticky(input_los_latch_r[i],
                                            clr_a && reg_wdata[`CSL_BIT_INPUT_LO + i],
                                            det_r.input_active[i]);
        end
        reference_valid_latch_nxt = sticky(reference_valid_latch_r,
                                           clr_b && reg_wdata[`CSL_BIT_REF],
                                           det_r.reference_present);
        holdover_latch_nxt        = sticky(holdover_latch_r,
                                           clr_b && reg_wdata[`CSL_BIT_HOLD],
                                           det_r.holdover);
        // A fall of the reference latch while its enable is set raises the flag; set beats clear
        ref_pend_nxt = ref_pend_r;
        if (clr_b && reg_wdata[`CSL_BIT_REF]) begin
            ref_pend_nxt = 1'b0;
        end
        if (reference_irq_enable_r && reference_valid_latch_r
            && !reference_valid_latch_nxt) begin
            ref_pend_nxt = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            synth_lock_irq_enable_r <= 1'b0;
            vcxo_lock_irq_enable_r  <= 1'b0;
            input_los_irq_enable_r  <= 4'h0;
            reference_irq_enable_r  <= 1'b0;
            holdover_irq_enable_r   <= 1'b0;
            synth_lock_loss_latch_r <= `CSL_RST_LATCH;
            vcxo_lock_loss_latch_r  <= `CSL_RST_LATCH;
            input_los_latch_r       <= {4{`CSL_RST_LATCH}};
            reference_valid_latch_r <= `CSL_RST_LATCH;
            holdover_latch_r        <= `CSL_RST_LATCH;
            ref_pend_r              <= 1'b0;
        end else begin
            synth_lock_irq_enable_r <= synth_lock_irq_enable_nxt;
            vcxo_lock_irq_enable_r  <= vcxo_lock_irq_enable_nxt;
            input_los_irq_enable_r  <= input_los_irq_enable_nxt;
            reference_irq_enable_r  <= reference_irq_enable_nxt;
            holdover_irq_enable_r   <= holdover_irq_enable_nxt;
            synth_lock_loss_latch_r <= synth_lock_loss_latch_nxt;
            vcxo_lock_loss_latch_r  <= vcxo_lock_loss_latch_nxt;
            input_los_latch_r       <= input_los_latch_nxt;
            reference_valid_latch_r <= reference_valid_latch_nxt;
            holdover_latch_r        <= holdover_latch_nxt;
            ref_pend_r              <= ref_pend_nxt;
        end
    end

    // Read data and interrupt pin, both registered
    csl_pkg::csl_byte_type rdata_nxt;
    logic                  irq_nxt;
    logic                  lock_irq;
    logic                  input_irq;
    logic                  hold_irq;

    always_comb begin
        rdata_nxt = 8'h00;
        case (reg_addr)
            `CSL_ADDR_IE_A: begin
                rdata_nxt = pack_a(synth_lock_irq_enable_r,
                                   vcxo_lock_irq_enable_r,
                                   input_los_irq_enable_r);
            end
            `CSL_ADDR_IE_B: begin
                rdata_nxt = pack_b(reference_irq_enable_r,
                                   holdover_irq_enable_r);
            end
            `CSL_ADDR_LATCH_A: begin
                rdata_nxt = pack_a(synth_lock_loss_latch_r,
                                   vcxo_lock_loss_latch_r,
                                   input_los_latch_r);
            end
            `CSL_ADDR_NOW_A: begin
                rdata_nxt = pack_a(det_r.synth_lock,
                                   det_r.vcxo_lock,
                                   det_r.input_active);
                // Selection status comes from same-clock logic and is not synchronised
                rdata_nxt[`CSL_BIT_SEL_LO +: 2] = selected_input_status;
            end
            `CSL_ADDR_LATCH_B: begin
                rdata_nxt = pack_b(reference_valid_latch_r,
                                   holdover_latch_r);
            end
            `CSL_ADDR_NOW_B: begin
                rdata_nxt[`CSL_BIT_CAL]  = det_r.cal_active;
                rdata_nxt[`CSL_BIT_REF]  = det_r.reference_present;
                rdata_nxt[`CSL_BIT_HOLD] = det_r.holdover;
            end
            default: begin
                rdata_nxt = 8'h00;
            end
        endcase
        // Level interrupt: stays low while any enabled lock, input or holdover latch holds an event, or the reference flag is pending.
        // Being a level, enabling a lock, input or holdover source that already holds an event asserts at once.
        lock_irq  = (synth_lock_irq_enable_r && !synth_lock_loss_latch_r)
                 || (vcxo_lock_irq_enable_r && !vcxo_lock_loss_latch_r);
        input_irq = |(input_los_irq_enable_r & ~input_los_latch_r);
        hold_irq  = holdover_irq_enable_r && !holdover_latch_r;
        irq_nxt   = !(lock_irq || input_irq || hold_irq || ref_pend_r);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata   <= `CSL_RST_RDATA;
            irq_out_low <= `CSL_RST_IRQ_LOW;
        end else begin
            reg_rdata   <= rdata_nxt;
            irq_out_low <= irq_nxt;
        end
    end

endmodule
`default_nettype wire

/* testbench/csl_top_props.sv */
// Port-level assertions for the status latch and interrupt block.
// Assumes it is bound to csl_top and that detector inputs change only between tests.
`timescale 1ns/1ps
`default_nettype none
`include "csl_consts.svh"
module csl_top_props #(
    parameter int N_INPUTS = 4
) (
    input wire logic                mclk,
    input wire logic                rst,
    input wire logic [7:0]          reg_addr,
    input wire logic                reg_wr,
    input wire logic [7:0]          reg_wdata,
    input wire logic [7:0]          reg_rdata,
    input wire logic                synth_lock_raw,
    input wire logic                vcxo_lock_raw,
    input wire logic [N_INPUTS-1:0] input_active_raw,
    input wire logic                reference_present_raw,
    input wire logic                holdover_raw,
    input wire logic                synth_cal_raw,
    input wire logic [1:0]          selected_input_status,
    input wire logic                irq_out_low
);
    logic wr_seen_r;
    logic wr_seen_nxt;
    always_comb begin
        wr_seen_nxt = wr_seen_r | reg_wr;
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_seen_r <= 1'b0;
        end else begin
            wr_seen_r <= wr_seen_nxt;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_wr(a);
        reg_wr && reg_addr == a;
    endsequence
    // Eight edges cover the three synchroniser stages plus filter and latch
    sequence s_low8(sig);
        (!sig) [*8];
    endsequence
    // Enables reset to 0, so nothing can interrupt before the first write
    property p_irq_quiet;
        !wr_seen_r |-> irq_out_low;
    endproperty
    property p_ie_a;
        logic [7:0] d;
        (s_wr(`CSL_ADDR_IE_A), d = reg_wdata) ##1 reg_addr == `CSL_ADDR_IE_A
            |=> reg_rdata == {2'b00, d[5:0]};
    endproperty
    property p_ie_b;
        logic [7:0] d;
        (s_wr(`CSL_ADDR_IE_B), d = reg_wdata) ##1 reg_addr == `CSL_ADDR_IE_B
            |=> reg_rdata == {6'h00, d[1:0]};
    endproperty
    property p_sel;
        reg_addr == `CSL_ADDR_NOW_A |=> reg_rdata[7:6] == $past(selected_input_status);
    endproperty
    property p_vcxo_latch;
        s_low8(vcxo_lock_raw) ##0 reg_addr == `CSL_ADDR_LATCH_A |=> !reg_rdata[4];
    endproperty
    property p_in0_latch;
        s_low8(input_active_raw[0]) ##0 reg_addr == `CSL_ADDR_LATCH_A |=> !reg_rdata[0];
    endproperty
    property p_ref_latch;
        s_low8(reference_present_raw) ##0 reg_addr == `CSL_ADDR_LATCH_B |=> !reg_rdata[1];
    endproperty
    property p_hold_latch;
        s_low8(holdover_raw) ##0 reg_addr == `CSL_ADDR_LATCH_B |=> !reg_rdata[0];
    endproperty
    property p_vcxo_now;
        s_low8(!vcxo_lock_raw) ##0 reg_addr == `CSL_ADDR_NOW_A |=> reg_rdata[4];
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq before any enable");
    a_ie_a: assert property (p_ie_a) else $error("enable group A readback");
    a_ie_b: assert property (p_ie_b) else $error("enable group B readback");
    a_sel: assert property (p_sel) else $error("selection status readback");
    a_vcxo_latch: assert property (p_vcxo_latch) else $error("vcxo latch missed");
    a_in0_latch: assert property (p_in0_latch) else $error("input latch missed");
    a_ref_latch: assert property (p_ref_latch) else $error("reference latch missed");
    a_hold_latch: assert property (p_hold_latch) else $error("holdover latch missed");
    a_vcxo_now: assert property (p_vcxo_now) else $error("vcxo momentary wrong");
endmodule
`default_nettype wire

/* testbench/csl_host.sv */
// Host model: register writes and reads, interrupt sampling, expected-value queue.
// Assumes one-cycle write strobes and read data one edge after the address.
`timescale 1ns/1ps
`default_nettype none
module csl_host (
    input  wire logic       mclk,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       irq_out_low,
    output var  logic [7:0] reg_addr,
    output var  logic       reg_wr,
    output var  logic [7:0] reg_wdata
);
    logic [7:0] exp_q[$];
    logic [7:0] seen;
    event       got;
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end
    // Write of 1 clears a sticky bit, 0 leaves it alone
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wr = 1'b1;
        reg_wdata = d;
        @(negedge mclk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk);
        reg_addr = a;
        repeat (2) @(negedge mclk);
        seen = reg_rdata;
        exp_q.push_back(e);
        -> got;
    endtask
    task automatic chk_irq(input logic e);
        @(negedge mclk);
        seen = {7'h00, irq_out_low};
        exp_q.push_back({7'h00, e});
        -> got;
    endtask
endmodule
`default_nettype wire

/* testbench/clock_status_latch_irq_bench.sv */
// Self-checking bench: host model drives registers, bench drives detector inputs.
// Assumes the checker is bound here and all detectors run on their raw inputs.
`timescale 1ns/1ps
`default_nettype none
module clock_status_latch_irq_bench;
    logic        mclk;
    logic        rst;
    logic [7:0]  reg_addr;
    logic        reg_wr;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic        irq_out_low;
    logic [5:0]  ra;
    logic [1:0]  rb;
    logic        cal;
    logic [1:0]  sel;
    logic [31:0] seed;
    int          failures;
    int          check_count;
    csl_top #(.N_INPUTS(4)) dut_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .synth_lock_raw(ra[5]), .vcxo_lock_raw(ra[4]), .input_active_raw(ra[3:0]),
        .reference_present_raw(rb[1]), .holdover_raw(rb[0]), .synth_cal_raw(cal),
        .selected_input_status(sel), .irq_out_low(irq_out_low));
    csl_host host_u (.mclk(mclk), .reg_rdata(reg_rdata), .irq_out_low(irq_out_low),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Sources 0-5 sit in group A, 6-7 in group B
    task automatic set_src(input int i, input logic v);
        @(negedge mclk);
        if (i < 6) ra[i] = v;
        else rb[i-6] = v;
        repeat (8) @(negedge mclk);
    endtask
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        logic [7:0] e;
        forever begin
            @(host_u.got);
            e = host_u.exp_q.pop_front();
            check_count++;
            if (host_u.seen !== e) begin
                failures++;
                $display("CHECK FAILED %0t: got %h expected %h", $time, host_u.seen, e);
            end
        end
    end
    initial begin
        #200000;
        failures++;
        give_verdict();
    end
    initial begin
        logic [7:0] la;
        logic [7:0] ie;
        logic [7:0] m;
        logic [7:0] full;
        ra = 6'h3f;
        rb = 2'b11;
        cal = 1'b0;
        sel = 2'b00;
        seed = 32'd79201;
        rst = 1'b1;
        repeat (16) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        // Detectors reset to healthy, so the latches must still show no event
        repeat (10) @(negedge mclk);
        host_u.rd(8'h6c, 8'h3f);
        host_u.rd(8'h6e, 8'h03);
        host_u.chk_irq(1'b1);
        host_u.wr(8'h6c, 8'h3f);
        host_u.wr(8'h6e, 8'h03);
        host_u.rd(8'h68, 8'h00);
        host_u.rd(8'h69, 8'h00);
        host_u.rd(8'h6c, 8'h3f);
        host_u.rd(8'h6e, 8'h03);
        host_u.chk_irq(1'b1);
        for (int s = 0; s < 4; s++) begin
            @(negedge mclk);
            sel = s[1:0];
            host_u.rd(8'h6d, {s[1:0], 6'h3f});
        end
        sel = 2'b00;
        cal = 1'b1;
        repeat (8) @(negedge mclk);
        host_u.rd(8'h6f, 8'h07);
        cal = 1'b0;
        repeat (8) @(negedge mclk);
        host_u.rd(8'h6f, 8'h03);
        seed = xs(seed);
        host_u.wr(8'h68, seed[7:0]);
        host_u.rd(8'h68, {2'b00, seed[5:0]});
        host_u.wr(8'h69, seed[15:8]);
        host_u.rd(8'h69, {6'h00, seed[9:8]});
        host_u.wr(8'h68, 8'h00);
        host_u.wr(8'h69, 8'h00);
        for (int i = 0; i < 8; i++) begin
            la = (i < 6) ? 8'h6c : 8'h6e;
            ie = (i < 6) ? 8'h68 : 8'h69;
            m = (i < 6) ? 8'h01 << i : 8'h01 << (i - 6);
            full = (i < 6) ? 8'h3f : 8'h03;
            host_u.wr(ie, m);
            set_src(i, 1'b0);
            host_u.chk_irq(1'b0);
            host_u.rd(la + 8'h01, full & ~m);
            host_u.wr(la, m);
            host_u.rd(la, full & ~m);
            set_src(i, 1'b1);
            // Clearing the reference latch under fault drops its pending flag
            host_u.chk_irq(i == 7);
            host_u.wr(la, m);
            host_u.chk_irq(1'b1);
            host_u.rd(la, full);
            host_u.wr(ie, 8'h00);
            set_src(i, 1'b0);
            host_u.chk_irq(1'b1);
            set_src(i, 1'b1);
            host_u.wr(la, m);
        end
        give_verdict();
    end
endmodule
bind csl_top csl_top_props #(.N_INPUTS(N_INPUTS)) chk_u (.mclk(mclk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .synth_lock_raw(synth_lock_raw), .vcxo_lock_raw(vcxo_lock_raw),
    .input_active_raw(input_active_raw), .reference_present_raw(reference_present_raw),
    .holdover_raw(holdover_raw), .synth_cal_raw(synth_cal_raw),
    .selected_input_status(selected_input_status), .irq_out_low(irq_out_low));
`default_nettype wire
